// ==== verilog/occ_map.svh ====
// register offsets, field positions, reset values and timing counts
`ifndef OCC_MAP_SVH
`define OCC_MAP_SVH

// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define OCC_ADDR_CMD 8'h42
`define OCC_ADDR_INIT 8'h43
`define OCC_ADDR_P2CTL 8'h2C
`define OCC_ADDR_MCCFG 8'h40

// ---------------------------------------------------------------
// command register fields
// ---------------------------------------------------------------
`define OCC_CMD_DLY_MSB 7
`define OCC_CMD_DLY_LSB 5
`define OCC_CMD_CODE_MSB 4
`define OCC_DLY_RESET 3'h1
`define OCC_DLY_RSVD 3'h0
`define OCC_CODE_NONE 5'h00
`define OCC_CODE_COND 5'h01
`define OCC_CODE_LOOP_START 5'h02
`define OCC_CODE_LOOP_STOP 5'h04
`define OCC_CODE_REMOTE 5'h08
`define OCC_CODE_INDICATE 5'h10

// ---------------------------------------------------------------
// initialize register bits and their alias positions
// ---------------------------------------------------------------
`define OCC_INIT_RATE 7
`define OCC_INIT_DUPLEX 6
`define OCC_INIT_AUTONEG 5
`define OCC_INIT_SWRST 4
`define OCC_INIT_REMOTE 3
`define OCC_INIT_LDPROP 2
`define OCC_INIT_FIBER_TRI 1
`define OCC_INIT_PHYRST 0
`define OCC_P2CTL_AUTONEG 7
`define OCC_P2CTL_RATE 6
`define OCC_P2CTL_DUPLEX 5

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define OCC_CLK_MHZ 250
`define OCC_DLY1_US 32
`define OCC_DLY2_US 128
`define OCC_DLY3_US 256
`define OCC_DLY4_US 512
`define OCC_DLY5_MS 1
`define OCC_DLY6_MS 2
`define OCC_DLY7_MS 4
`define OCC_DLY1_CYC (`OCC_DLY1_US * `OCC_CLK_MHZ)
`define OCC_DLY2_CYC (`OCC_DLY2_US * `OCC_CLK_MHZ)
`define OCC_DLY3_CYC (`OCC_DLY3_US * `OCC_CLK_MHZ)
`define OCC_DLY4_CYC (`OCC_DLY4_US * `OCC_CLK_MHZ)
`define OCC_DLY5_CYC (`OCC_DLY5_MS * 1000 * `OCC_CLK_MHZ)
`define OCC_DLY6_CYC (`OCC_DLY6_MS * 1000 * `OCC_CLK_MHZ)
`define OCC_DLY7_CYC (`OCC_DLY7_MS * 1000 * `OCC_CLK_MHZ)
`define OCC_DLY_W 20
`define OCC_SOFT_RST_CYC 16

`endif

// ==== verilog/occ_pkg.sv ====
// types shared by the maintenance command and init control block
package occ_pkg;

    // ---------------------------------------------------------------
    // frame kinds and command state
    // ---------------------------------------------------------------
    typedef enum logic [2:0] {
        OCC_FRM_COND,
        OCC_FRM_LOOP_START,
        OCC_FRM_LOOP_STOP,
        OCC_FRM_REMOTE,
        OCC_FRM_INDICATE
    } occ_frame_t;

    typedef enum logic {
        OCC_ST_IDLE,
        OCC_ST_PEND
    } occ_state_t;

    // ---------------------------------------------------------------
    // carriers
    // ---------------------------------------------------------------
    typedef struct packed {
        logic valid;
        occ_frame_t kind;
    } occ_frame_req_t;

    typedef struct packed {
        logic rate_select;
        logic duplex_select;
        logic autoneg_enable;
    } occ_port2_cfg_t;

    typedef struct packed {
        logic copper_tx_disable;
        logic copper_led_off;
        logic fiber_tx_tristate;
    } occ_link_ctl_t;

endpackage : occ_pkg

// ==== verilog/occ_reset_pulse.sv ====
// stretches a one-cycle reset request into a fixed-length reset pulse
`timescale 1ns/1ns
`include "occ_map.svh"

module occ_reset_pulse
    import occ_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // request and pulse
    input wire logic start,
    output logic active
);

    logic [7:0] count;
    wire logic last = (count == 8'h01);

    // a repeated request while active restarts the full length
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            count <= 8'h00;
            active <= 1'b0;
        end
        else if (start)
        begin
            count <= 8'(`OCC_SOFT_RST_CYC);
            active <= 1'b1;
        end
        else if (active)
        begin
            count <= count - 8'h01;
            active <= !last;
        end
    end

endmodule : occ_reset_pulse

// ==== verilog/occ_regs.sv ====
// maintenance command and phy/switch initialize registers
//
// Overview of operation
// - delay code 001..111 gives 32us..4ms reply timer; resets 001; 000 reserved.
// - code 0 0001 sends one condition inform request frame.
// - code 0 0010 sends a loop mode start request frame.
// - code 0 0100 sends a loop mode stop request frame.
// - code 0 1000 sends remote command frame using alternate model info registers.
// - code 1 0000 sends the indicate condition frame on demand.
// - all other command frames go out only in central-office mode.
// - init bit 7 is port 2 speed, aliases 2Ch bit 6, strap reset.
// - init bit 6 is port 2 duplex, aliases 2Ch bit 5, strap reset.
// - init bit 5 is port 2 autoneg enable, aliases 2Ch bit 7, strap reset.
// - writing 1 to bit 4 resets sub-layer, macs, fabric; self-clears.
// - bit 3 enables remote command access on both sides; resets to 0.
// - terminal mode with bit 2: link down disables copper tx and leds.
// - bit 2 ignored in central-office mode; reset value from strap.
// - bit 1 tri-states fiber transmit of port 1; resets to 0.
// - bit 0 resets both phys, self-clears; reads 1 in central mode until 0x40 written.
`timescale 1ns/1ns
`include "occ_map.svh"

module occ_regs
    import occ_pkg::*;
#(
    parameter int unsigned DLY1_CYC = `OCC_DLY1_CYC,
    parameter int unsigned DLY2_CYC = `OCC_DLY2_CYC,
    parameter int unsigned DLY3_CYC = `OCC_DLY3_CYC,
    parameter int unsigned DLY4_CYC = `OCC_DLY4_CYC,
    parameter int unsigned DLY5_CYC = `OCC_DLY5_CYC,
    parameter int unsigned DLY6_CYC = `OCC_DLY6_CYC,
    parameter int unsigned DLY7_CYC = `OCC_DLY7_CYC
)
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // straps and mode
    input wire logic port2_rate_strap,
    input wire logic port2_duplex_strap,
    input wire logic port2_autoneg_strap,
    input wire logic linkdown_propagate_strap,
    input wire logic media_converter_center,
    // register port
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // maintenance frame launch
    output occ_frame_req_t frame_req,
    input wire logic frame_ack,
    output logic [`OCC_DLY_W-1:0] reply_delay_cycles,
    // link status
    input wire logic fiber_link_up,
    input wire logic center_copper_link_up,
    // control outputs
    output occ_port2_cfg_t port2_cfg,
    output occ_link_ctl_t link_ctl,
    output logic remote_cmd_enable,
    output logic mc_switch_reset,
    output logic phy_soft_reset
);

    // ---------------------------------------------------------------
    // command decode
    // ---------------------------------------------------------------
    function automatic logic code_defined(input logic [4:0] code);
        code_defined = (code == `OCC_CODE_COND) || (code == `OCC_CODE_LOOP_START) ||
                       (code == `OCC_CODE_LOOP_STOP) || (code == `OCC_CODE_REMOTE) ||
                       (code == `OCC_CODE_INDICATE);
    endfunction : code_defined

    function automatic occ_frame_t code_kind(input logic [4:0] code);
        case (code)
            `OCC_CODE_LOOP_START: code_kind = OCC_FRM_LOOP_START;
            `OCC_CODE_LOOP_STOP: code_kind = OCC_FRM_LOOP_STOP;
            `OCC_CODE_REMOTE: code_kind = OCC_FRM_REMOTE;
            `OCC_CODE_INDICATE: code_kind = OCC_FRM_INDICATE;
            default: code_kind = OCC_FRM_COND;
        endcase
    endfunction : code_kind

    // ---------------------------------------------------------------
    // storage
    // ---------------------------------------------------------------
    logic [2:0] delay_code;
    logic [4:0] cmd_code;
    occ_state_t state;
    logic rate_select;
    logic duplex_select;
    logic autoneg_enable;
    logic remote_enable;
    logic ldprop_enable;
    logic fiber_tri;
    logic phy_hold;
    logic [1:0] pulse_start;
    logic [1:0] pulse_busy;

    // ---------------------------------------------------------------
    // write decode
    // ---------------------------------------------------------------
    wire logic wr_cmd = reg_wr_en && (reg_addr == `OCC_ADDR_CMD);
    wire logic wr_init = reg_wr_en && (reg_addr == `OCC_ADDR_INIT);
    wire logic wr_p2ctl = reg_wr_en && (reg_addr == `OCC_ADDR_P2CTL);
    wire logic wr_mccfg = reg_wr_en && (reg_addr == `OCC_ADDR_MCCFG);
    wire logic [4:0] wr_code = reg_wdata[`OCC_CMD_CODE_MSB:0];
    wire logic [2:0] wr_delay = reg_wdata[`OCC_CMD_DLY_MSB:`OCC_CMD_DLY_LSB];
    wire logic sw_rst_busy = pulse_busy[0];

    // non-indicate frames originate only on the central-office side,
    // and a remote command also needs remote access enabled
    wire logic side_ok = media_converter_center || (wr_code == `OCC_CODE_INDICATE);
    wire logic remote_ok = (wr_code != `OCC_CODE_REMOTE) || remote_enable;
    wire logic launch = wr_cmd && (state == OCC_ST_IDLE) && code_defined(wr_code) &&
                        side_ok && remote_ok;

    // ---------------------------------------------------------------
    // delay code to cycle count
    // ---------------------------------------------------------------
    logic [`OCC_DLY_W-1:0] next_delay_cycles;

    always_comb
    begin
        case (delay_code)
            3'h2: next_delay_cycles = `OCC_DLY_W'(DLY2_CYC);
            3'h3: next_delay_cycles = `OCC_DLY_W'(DLY3_CYC);
            3'h4: next_delay_cycles = `OCC_DLY_W'(DLY4_CYC);
            3'h5: next_delay_cycles = `OCC_DLY_W'(DLY5_CYC);
            3'h6: next_delay_cycles = `OCC_DLY_W'(DLY6_CYC);
            3'h7: next_delay_cycles = `OCC_DLY_W'(DLY7_CYC);
            default: next_delay_cycles = `OCC_DLY_W'(DLY1_CYC);
        endcase
    end

    // ---------------------------------------------------------------
    // command register and frame launch
    // ---------------------------------------------------------------
    // a switch soft reset returns the maintenance sub-layer to defaults,
    // which drops any frame still waiting for the frame engine
    always_ff @(posedge sys_clk)
    begin
        if (rst || sw_rst_busy)
        begin
            delay_code <= `OCC_DLY_RESET;
            cmd_code <= `OCC_CODE_NONE;
            state <= OCC_ST_IDLE;
            frame_req <= '0;
        end
        else
        begin
            if (wr_cmd && (wr_delay != `OCC_DLY_RSVD))
            begin
                delay_code <= wr_delay;
            end
            case (state)
                OCC_ST_IDLE:
                begin
                    // an undefined or disallowed code stores as no request
                    if (launch)
                    begin
                        cmd_code <= wr_code;
                        state <= OCC_ST_PEND;
                        frame_req.valid <= 1'b1;
                        frame_req.kind <= code_kind(wr_code);
                    end
                end
                OCC_ST_PEND:
                begin
                    // further command codes are ignored until the frame goes; the delay field still updates
                    if (frame_ack)
                    begin
                        cmd_code <= `OCC_CODE_NONE;
                        state <= OCC_ST_IDLE;
                        frame_req.valid <= 1'b0;
                    end
                end
                default:
                begin
                    state <= OCC_ST_IDLE;
                    frame_req.valid <= 1'b0;
                end
            endcase
        end
    end

    // ---------------------------------------------------------------
    // port 2 settings, shared with the 2Ch alias
    // ---------------------------------------------------------------
    // straps are caught by the synchronous reset, so the strap level
    // must be steady while rst is high
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            rate_select <= port2_rate_strap;
            duplex_select <= port2_duplex_strap;
            autoneg_enable <= port2_autoneg_strap;
        end
        else if (wr_init)
        begin
            rate_select <= reg_wdata[`OCC_INIT_RATE];
            duplex_select <= reg_wdata[`OCC_INIT_DUPLEX];
            autoneg_enable <= reg_wdata[`OCC_INIT_AUTONEG];
        end
        else if (wr_p2ctl)
        begin
            rate_select <= reg_wdata[`OCC_P2CTL_RATE];
            duplex_select <= reg_wdata[`OCC_P2CTL_DUPLEX];
            autoneg_enable <= reg_wdata[`OCC_P2CTL_AUTONEG];
        end
    end

    // ---------------------------------------------------------------
    // initialize register control bits
    // ---------------------------------------------------------------
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            remote_enable <= 1'b0;
            ldprop_enable <= linkdown_propagate_strap;
            fiber_tri <= 1'b0;
        end
        else if (wr_init)
        begin
            remote_enable <= reg_wdata[`OCC_INIT_REMOTE];
            ldprop_enable <= reg_wdata[`OCC_INIT_LDPROP];
            fiber_tri <= reg_wdata[`OCC_INIT_FIBER_TRI];
        end
    end

    // central-office power-up holds the phys in reset until the
    // maintenance configuration register is first programmed
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            phy_hold <= media_converter_center;
        end
        else if (wr_mccfg)
        begin
            phy_hold <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // self-clearing reset pulses: 0 switch, 1 phy
    // ---------------------------------------------------------------
    assign pulse_start[0] = wr_init && reg_wdata[`OCC_INIT_SWRST];
    assign pulse_start[1] = wr_init && reg_wdata[`OCC_INIT_PHYRST];

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++)
        begin : g_pulse
            occ_reset_pulse u_pulse (
                .sys_clk(sys_clk),
                .rst(rst),
                .start(pulse_start[gi]),
                .active(pulse_busy[gi])
            );
        end
    endgenerate

    // ---------------------------------------------------------------
    // read mux
    // ---------------------------------------------------------------
    wire logic [7:0] rd_cmd = {delay_code, cmd_code};
    wire logic phy_rd_bit = pulse_busy[1] || phy_hold;
    wire logic [7:0] rd_init = {rate_select, duplex_select, autoneg_enable,
                                pulse_busy[0], remote_enable, ldprop_enable,
                                fiber_tri, phy_rd_bit};
    wire logic [7:0] rd_p2ctl = {autoneg_enable, rate_select, duplex_select, 5'h00};
    logic [7:0] next_rdata;

    always_comb
    begin
        case (reg_addr)
            `OCC_ADDR_CMD: next_rdata = rd_cmd;
            `OCC_ADDR_INIT: next_rdata = rd_init;
            `OCC_ADDR_P2CTL: next_rdata = rd_p2ctl;
            default: next_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            reg_rdata <= 8'h00;
        end
        else if (reg_rd_en)
        begin
            reg_rdata <= next_rdata;
        end
    end

    // ---------------------------------------------------------------
    // link-down propagation, terminal side only
    // ---------------------------------------------------------------
    wire logic any_link_down = !fiber_link_up || !center_copper_link_up;
    wire logic terminal_kill = !media_converter_center && ldprop_enable &&
                               any_link_down;

    // ---------------------------------------------------------------
    // registered outputs
    // ---------------------------------------------------------------
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            port2_cfg <= '0;
            link_ctl <= '0;
            remote_cmd_enable <= 1'b0;
            mc_switch_reset <= 1'b0;
            phy_soft_reset <= 1'b0;
            reply_delay_cycles <= '0;
        end
        else
        begin
            port2_cfg.rate_select <= rate_select;
            port2_cfg.duplex_select <= duplex_select;
            port2_cfg.autoneg_enable <= autoneg_enable;
            link_ctl.copper_tx_disable <= terminal_kill;
            link_ctl.copper_led_off <= terminal_kill;
            link_ctl.fiber_tx_tristate <= fiber_tri;
            remote_cmd_enable <= remote_enable;
            mc_switch_reset <= pulse_busy[0];
            phy_soft_reset <= pulse_busy[1] || phy_hold;
            reply_delay_cycles <= next_delay_cycles;
        end
    end

endmodule : occ_regs

// ==== dv/occ_frame_engine_model.sv ====
// frame engine model that takes launch requests and acknowledges them
`timescale 1ns/1ns

module occ_frame_engine_model
    import occ_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // launch handshake
    input wire occ_frame_req_t frame_req,
    input wire logic [3:0] ack_wait,
    output logic frame_ack = 1'b0,
    // what was taken
    output logic [7:0] seen_count,
    output occ_frame_t seen_kind
);
    logic [3:0] wait_cnt = 4'h0;

    // ack is one cycle wide; a longer pulse would swallow a second request
    always @(negedge sys_clk)
    begin
        if (rst || frame_ack || !frame_req.valid)
        begin
            frame_ack <= 1'b0;
            wait_cnt <= 4'h0;
        end
        else if (wait_cnt >= ack_wait)
            frame_ack <= 1'b1;
        else
            wait_cnt <= wait_cnt + 4'h1;
    end

    always @(posedge sys_clk)
    begin
        if (rst)
            seen_count <= 8'h00;
        else if (frame_req.valid && frame_ack)
        begin
            seen_count <= seen_count + 8'h01;
            seen_kind <= frame_req.kind;
        end
    end
endmodule : occ_frame_engine_model

// ==== dv/occ_regs_assertions.sv ====
// concurrent checks on the ports of the command and init registers
`timescale 1ns/1ns
`include "occ_map.svh"

module occ_regs_assertions
    import occ_pkg::*;
#(
    parameter int unsigned DLY1_CYC = 1,
    parameter int unsigned DLY2_CYC = 2,
    parameter int unsigned DLY3_CYC = 3,
    parameter int unsigned DLY4_CYC = 4,
    parameter int unsigned DLY5_CYC = 5,
    parameter int unsigned DLY6_CYC = 6,
    parameter int unsigned DLY7_CYC = 7
)
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // inputs
    input wire logic media_converter_center,
    input wire logic reg_wr_en,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic frame_ack,
    // outputs
    input wire occ_frame_req_t frame_req,
    input wire logic [`OCC_DLY_W-1:0] reply_delay_cycles,
    input wire occ_port2_cfg_t port2_cfg,
    input wire occ_link_ctl_t link_ctl,
    input wire logic mc_switch_reset,
    input wire logic phy_soft_reset
);
    localparam int unsigned DLY_TAB [8] = '{0, DLY1_CYC, DLY2_CYC, DLY3_CYC, DLY4_CYC, DLY5_CYC, DLY6_CYC, DLY7_CYC};
    // only idle-state writes with a legal delay code count as taken
    wire cmd_wr = reg_wr_en && reg_addr == `OCC_ADDR_CMD && !frame_req.valid && reg_wdata[7:5] != 3'h0;
    wire init_wr = reg_wr_en && reg_addr == `OCC_ADDR_INIT;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    property p_req_hold; frame_req.valid && !frame_ack |=> frame_req.valid && $stable(frame_req.kind); endproperty
    a_req_hold: assert property (p_req_hold) else $error("launch request changed before ack");
    property p_req_drop; frame_req.valid && frame_ack |=> !frame_req.valid; endproperty
    a_req_drop: assert property (p_req_drop) else $error("launch request held after ack");
    property p_cond; cmd_wr && reg_wdata[4:0] == `OCC_CODE_COND && media_converter_center ##1 !mc_switch_reset
        |-> frame_req.valid && frame_req.kind == OCC_FRM_COND; endproperty
    a_cond: assert property (p_cond) else $error("condition request not launched");
    property p_term; cmd_wr && !media_converter_center && reg_wdata[4:0] != `OCC_CODE_INDICATE |=> !frame_req.valid;
    endproperty
    a_term: assert property (p_term) else $error("terminal side launched a center frame");
    property p_dly; cmd_wr ##1 !mc_switch_reset && !reg_wr_en
        |-> ##1 reply_delay_cycles == DLY_TAB[$past(reg_wdata[7:5], 2)]; endproperty
    a_dly: assert property (p_dly) else $error("reply delay count wrong");
    property p_swrst; init_wr && reg_wdata[`OCC_INIT_SWRST] |-> ##2 mc_switch_reset [*8] ##1 mc_switch_reset [*8];
    endproperty
    a_swrst: assert property (p_swrst) else $error("switch reset pulse short");
    property p_phyrst; init_wr && reg_wdata[`OCC_INIT_PHYRST] |-> ##2 phy_soft_reset [*8] ##1 phy_soft_reset [*8]; endproperty
    a_phyrst: assert property (p_phyrst) else $error("phy_soft_reset pulse short");
    property p_alias; reg_wr_en && reg_addr == `OCC_ADDR_P2CTL ##1 !reg_wr_en
        |-> ##1 port2_cfg == {$past(reg_wdata[6], 2), $past(reg_wdata[5], 2), $past(reg_wdata[7], 2)}; endproperty
    a_alias: assert property (p_alias) else $error("port 2 alias mismatch");
    property p_center; media_converter_center && $past(media_converter_center)
        |-> !link_ctl.copper_tx_disable && !link_ctl.copper_led_off; endproperty
    a_center: assert property (p_center) else $error("link down action in center mode");
endmodule : occ_regs_assertions

bind occ_regs occ_regs_assertions #(.DLY1_CYC(DLY1_CYC), .DLY2_CYC(DLY2_CYC), .DLY3_CYC(DLY3_CYC),
    .DLY4_CYC(DLY4_CYC), .DLY5_CYC(DLY5_CYC), .DLY6_CYC(DLY6_CYC), .DLY7_CYC(DLY7_CYC)) i_occ_regs_assertions (
    .sys_clk, .rst, .media_converter_center, .reg_wr_en, .reg_addr, .reg_wdata, .frame_ack, .frame_req,
    .reply_delay_cycles, .port2_cfg, .link_ctl, .mc_switch_reset, .phy_soft_reset);

// ==== dv/occ_regs_tb_top.sv ====
// self-checking bench for the command and init registers
`timescale 1ns/1ns
`include "occ_map.svh"

module occ_regs_tb_top
    import occ_pkg::*;
;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic wr = 1'b0, rd = 1'b0, mcc = 1'b1, fib = 1'b1, cop = 1'b1, ack, swr, phr, rce;
    logic [7:0] addr = 8'h00, wd = 8'h00, rdata, fe_cnt;
    logic [3:0] ack_wait = 4'h5;
    logic [`OCC_DLY_W-1:0] dly;
    occ_frame_req_t req;
    occ_frame_t fe_kind;
    occ_port2_cfg_t p2;
    occ_link_ctl_t lc;
    int err_count = 0, samples_checked = 0, cyc = 0, sw_hi = 0, ph_hi = 0;
    logic s_rt = 1'b1, s_dx = 1'b0, s_an = 1'b1, s_ld = 1'b1;
    int unsigned dtab[8] = '{0, `OCC_DLY1_CYC, `OCC_DLY2_CYC, `OCC_DLY3_CYC, `OCC_DLY4_CYC,
        `OCC_DLY5_CYC, `OCC_DLY6_CYC, `OCC_DLY7_CYC};

    occ_regs i_occ_regs (
        .sys_clk, .rst, .port2_rate_strap(s_rt), .port2_duplex_strap(s_dx), .port2_autoneg_strap(s_an),
        .linkdown_propagate_strap(s_ld), .media_converter_center(mcc), .reg_wr_en(wr), .reg_rd_en(rd),
        .reg_addr(addr), .reg_wdata(wd), .reg_rdata(rdata), .frame_req(req), .frame_ack(ack),
        .reply_delay_cycles(dly), .fiber_link_up(fib), .center_copper_link_up(cop), .port2_cfg(p2),
        .link_ctl(lc), .remote_cmd_enable(rce), .mc_switch_reset(swr), .phy_soft_reset(phr));
    occ_frame_engine_model i_occ_frame_engine_model (
        .sys_clk, .rst, .frame_req(req), .ack_wait, .frame_ack(ack), .seen_count(fe_cnt), .seen_kind(fe_kind));

    initial
    begin
        forever #2 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk)
    begin
        cyc++;
        sw_hi += int'(swr === 1'b1);
        ph_hi += int'(phr === 1'b1);
        if (cyc == 20000)
        begin
            err_count++;
            close_out();
        end
    end

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            err_count++;
            $display("BAD %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask : chk

    task automatic wrr(input logic [7:0] a, input logic [7:0] d);
        wr = 1'b1;
        addr = a;
        wd = d;
        @(negedge sys_clk);
        wr = 1'b0;
        @(negedge sys_clk);
    endtask : wrr

    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        rd = 1'b1;
        addr = a;
        @(negedge sys_clk);
        rd = 1'b0;
        chk("rdata", rdata, e);
        @(negedge sys_clk);
    endtask : rdc

    // a second command is written after the readback and must be dropped; with ack_wait 5 the first is still pending then
    task automatic send(input logic [4:0] code, input logic go, input occ_frame_t k);
        logic [7:0] c0;
        c0 = fe_cnt;
        wrr(8'h42, {3'b001, code});
        if (go)
        begin
            rdc(8'h42, {3'b001, code});
            wrr(8'h42, 8'h22);
            for (int i = 0; i < 50 && fe_cnt == c0; i++)
                @(negedge sys_clk);
            chk("frame_kind", fe_kind, k);
        end
        repeat (20) @(negedge sys_clk);
        chk("frame_count", fe_cnt, c0 + go);
        rdc(8'h42, 8'h20);
    endtask : send

    task automatic lk(input logic f, input logic c, input logic [2:0] e);
        fib = f;
        cop = c;
        repeat (2) @(negedge sys_clk);
        chk("link_ctl", lc, e);
    endtask : lk

    task automatic t_reset();
        rdc(8'h42, 8'h20);
        rdc(8'h43, 8'hA5);
        rdc(8'h2C, 8'hC0);
        chk("port2_cfg", p2, 3'b101);
        chk("phy_soft_reset", phr, 1'b1);
        wrr(8'h40, 8'h00);
        rdc(8'h43, 8'hA4);
        chk("phy_soft_reset", phr, 1'b0);
        wrr(8'h2C, 8'h40);
        rdc(8'h43, 8'h84);
        chk("port2_cfg", p2, 3'b100);
        wrr(8'h2C, 8'hC0);
        rdc(8'h55, 8'h00);
    endtask : t_reset

    task automatic t_delay();
        for (int d = 1; d < 8; d++)
        begin
            wrr(8'h42, {d[2:0], 5'h00});
            rdc(8'h42, {d[2:0], 5'h00});
            chk("reply_delay", dly, dtab[d]);
        end
        wrr(8'h42, 8'h00);
        rdc(8'h42, 8'hE0);
        wrr(8'h42, 8'h20);
    endtask : t_delay

    task automatic t_frames();
        wrr(8'h43, 8'hA8);
        send(5'h01, 1'b1, OCC_FRM_COND);
        send(5'h02, 1'b1, OCC_FRM_LOOP_START);
        send(5'h04, 1'b1, OCC_FRM_LOOP_STOP);
        send(5'h08, 1'b1, OCC_FRM_REMOTE);
        send(5'h10, 1'b1, OCC_FRM_INDICATE);
        chk("remote_en", rce, 1'b1);
    endtask : t_frames

    task automatic t_refuse();
        ack_wait = 4'h2;
        send(5'h03, 1'b0, OCC_FRM_COND);
        send(5'h00, 1'b0, OCC_FRM_COND);
        wrr(8'h43, 8'hA0);
        send(5'h08, 1'b0, OCC_FRM_COND);
        chk("remote_en", rce, 1'b0);
        mcc = 1'b0;
        send(5'h01, 1'b0, OCC_FRM_COND);
        send(5'h04, 1'b0, OCC_FRM_COND);
        send(5'h10, 1'b1, OCC_FRM_INDICATE);
        wrr(8'h43, 8'hA6);
        lk(1'b0, 1'b1, 3'b111);
        lk(1'b1, 1'b0, 3'b111);
        lk(1'b1, 1'b1, 3'b001);
        mcc = 1'b1;
        lk(1'b0, 1'b0, 3'b001);
        wrr(8'h43, 8'hA0);
        lk(1'b1, 1'b1, 3'b000);
    endtask : t_refuse

    task automatic t_softrst();
        wrr(8'h42, 8'hE0);
        sw_hi = 0;
        wrr(8'h43, 8'hB0);
        rdc(8'h43, 8'hB0);
        repeat (24) @(negedge sys_clk);
        chk("swrst_cycles", sw_hi, 16);
        rdc(8'h43, 8'hA0);
        rdc(8'h42, 8'h20);
        ph_hi = 0;
        wrr(8'h43, 8'hA1);
        rdc(8'h43, 8'hA1);
        repeat (24) @(negedge sys_clk);
        chk("phy_cycles", ph_hi, 16);
        rdc(8'h43, 8'hA0);
    endtask : t_softrst

    task automatic t_strap();
        {s_rt, s_dx, s_an, s_ld} = 4'h4;
        mcc = 1'b0;
        rst = 1'b1;
        repeat (5) @(negedge sys_clk);
        rst = 1'b0;
        rdc(8'h43, 8'h40);
        rdc(8'h2C, 8'h20);
        chk("port2_cfg", p2, 3'b010);
        chk("phy_soft_reset", phr, 1'b0);
    endtask : t_strap

    task automatic close_out();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : close_out

    initial
    begin
        repeat (5) @(negedge sys_clk);
        rst = 1'b0;
        repeat (2) @(negedge sys_clk);
        t_reset();
        t_delay();
        t_frames();
        t_refuse();
        t_softrst();
        t_strap();
        close_out();
    end
endmodule : occ_regs_tb_top
